// [rtl/drive_seq_defines.svh]
// Purpose: Constants of the start/stop sequencer: offsets, fields, resets, timing
// Assumes: 250 MHz core clock, timers counted in 10 ms ticks
// Notes:   Frequencies in 0.01 Hz, currents in percent, times in 0.01 s or 0.1 s
// Operation
// - Direct start: zero brake time starts at start frequency, else brake first.
// - Start mode 0 direct, 1 speed tracking, 2 pre-excitation; tracking finds speed first.
// - Pre-excitation with zero time starts at once, else excites for that time.
// - Output stays at start frequency for start hold time before accelerating.
// - Start frequency ignores lower limit; target below it keeps drive in standby.
// - Start hold is skipped when switching forward/reverse.
// - Start hold is outside ramp timing but inside sequential program run time.
// - Start DC braking only in direct start, current 0-100 %, zero time disables.
// - Tracking search starts at last frequency, zero, or maximum for 0, 1, 2.
// - Tracking rate 1-100 default 20 and search current default 125 % passed on.
// - Stop mode 0 ramps frequency down and stops at zero.
// - Stop mode 1 cuts output at once and lets the motor coast.
// - At braking frequency: output off for wait, then DC brake; zero time cancels.
// - Stop DC braking current is relative to motor rated current.
// - At stop frequency output holds for stop hold time, then blocks.
// - Power-loss restart 0 with run held starts after self-check plus wait.
// - Power-loss restart 1 needs the run command dropped and given again.
// - Set below lower limit: 0 runs at limit, 1 stops, 2 runs at zero.
// - Set below start frequency: 0 does not start, 1 runs at zero speed.
// - Run direction 1 inverts the commanded rotation, 0 keeps it.
// - Reverse prohibit 1 refuses reverse running.
// - Direction change holds 0 Hz for dead time before ramping the other way.
`ifndef DRIVE_SEQ_DEFINES_SVH
`define DRIVE_SEQ_DEFINES_SVH

// ****************************
// Register offsets
// ****************************
`define REG_MODES      8'h00
`define REG_START      8'h04
`define REG_BRAKE      8'h08
`define REG_STOP_FREQS 8'h0c
`define REG_STOP_TIMES 8'h10
`define REG_RESTART    8'h14
`define REG_STATUS     8'h18
`define REG_COUNT      3'h6

// ****************************
// Field positions
// ****************************
`define F_START_MODE     1:0
`define F_TRACK_MODE     3:2
`define F_STOP_MODE      4
`define F_PWR_RESTART    5
`define F_BELOW_LOWER    7:6
`define F_BELOW_START    8
`define F_DIR_INVERT     9
`define F_REV_PROHIBIT   10
`define F_TRACK_RATE     17:11
`define F_TRACK_CURRENT  25:18
`define F_START_FREQ     15:0
`define F_START_HOLD     31:16
`define F_START_BRK_CUR  6:0
`define F_STOP_BRK_CUR   13:7
`define F_START_BRK_TIME 25:16
`define F_STOP_BRK_FREQ  15:0
`define F_STOP_FREQ      31:16
`define F_STOP_BRK_WAIT  9:0
`define F_STOP_BRK_TIME  19:10
`define F_STOP_HOLD      29:20
`define F_PWR_WAIT       9:0
`define F_DEAD_TIME      24:10

// ****************************
// Reset values
// ****************************
`define RST_MODES      32'h01f4a100
`define RST_START      32'h00000032
`define RST_BRAKE      32'h00000000
`define RST_STOP_FREQS 32'h00320000
`define RST_STOP_TIMES 32'h00000000
`define RST_RESTART    32'h00000000

// ****************************
// Timing
// ****************************
`define CORE_CLK_MHZ    250
`define TICK_PERIOD_MS  10
`define TICK_CYCLES     (`TICK_PERIOD_MS * `CORE_CLK_MHZ * 1000)
`define TICKS_PER_TENTH (100 / `TICK_PERIOD_MS)

`endif

// [rtl/drive_seq_pkg.sv]
// Purpose: Types of the start/stop sequencer
// Assumes: Constants come from drive_seq_defines.svh
// Notes:   State codes step by one bit in the order they are listed
`default_nettype none

package drive_seq_pkg;

  typedef enum logic [3:0] {
    ST_IDLE        = 4'h0,
    ST_START_HOLD  = 4'h1,
    ST_RUN         = 4'h3,
    ST_DEC         = 4'h2,
    ST_STOP_HOLD   = 4'h6,
    ST_STOP_WAIT   = 4'h7,
    ST_STOP_BRAKE  = 4'h5,
    ST_DEAD_ZONE   = 4'h4,
    ST_START_BRAKE = 4'hc,
    ST_EXCITE      = 4'hd,
    ST_TRACK       = 4'hf,
    ST_RESTART     = 4'he
  } seq_state_t;

  typedef struct packed {
    logic        out_en;
    logic [15:0] freq_cmd;
    logic        ramp_en;
    logic        dc_brake;
    logic        pre_excite;
    logic [7:0]  current_pct;
    logic        cur_motor_ref;
    logic        track_active;
    logic [15:0] track_init_freq;
    logic [6:0]  track_rate;
    logic [7:0]  track_current;
    logic        rotate_rev;
    logic        prog_time_en;
  } drive_cmd_t;

  typedef struct packed {
    seq_state_t       state;
    logic [5:0][31:0] cfg;
    logic [31:0]      rdata;
    logic [21:0]      div;
    logic             tick;
    logic [19:0]      timer;
    logic [15:0]      hold_freq;
    logic [15:0]      last_freq;
    logic             dir;
    logic             rev_pend;
    logic             boot;
    logic             block;
    logic             run_s1;
    logic             run_s2;
    logic             rev_s1;
    logic             rev_s2;
    logic             pok_s1;
    logic             pok_s2;
    drive_cmd_t       drv;
  } seq_regs_t;

endpackage

`default_nettype wire

// [rtl/drive_start_stop_sequencer.sv]
// Purpose: Start/stop sequencing of a variable-frequency drive
// Assumes: Ramp generator, tracking estimator and power stage sit outside
// Notes:   Run, reverse and power-good arrive from pins and are synchronised
`include "drive_seq_defines.svh"
`default_nettype none

module drive_start_stop_sequencer #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                     CORE_CLK,
  input  wire logic                     RESET,
  input  wire logic [7:0]               REG_ADDR,
  input  wire logic [31:0]              REG_WDATA,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  output var  logic [31:0]              REG_RDATA,
  input  wire logic                     RUN_CMD,
  input  wire logic                     REV_CMD,
  input  wire logic                     POWER_OK,
  input  wire logic [15:0]              SET_FREQ,
  input  wire logic [15:0]              LOWER_LIMIT,
  input  wire logic [15:0]              MAX_FREQ,
  input  wire logic [15:0]              RAMP_FREQ,
  input  wire logic                     TRACK_DONE,
  output var  drive_seq_pkg::drive_cmd_t DRIVE
);

  drive_seq_pkg::seq_regs_t s;
  drive_seq_pkg::seq_regs_t n;
  logic [2:0]               wr_idx;
  logic [2:0]               rd_idx;
  logic                     below_lower;
  logic                     stop_by_lower;
  logic                     zero_by_lower;
  logic [15:0]              lower_tgt;
  logic                     below_start;
  logic                     go;
  logic [15:0]              tgt;
  logic                     rev_refused;
  logic                     run_ok;
  logic                     hold_bypass;

  // ****************************
  // Helpers
  // ****************************
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    if (a[1:0] != 2'h0 || a[7:5] != 3'h0 || a[4:2] == 3'h7) begin
      return 3'h7;
    end
    return a[4:2];
  endfunction

  function automatic logic [19:0] tenths(input logic [14:0] v);
    return 20'(32'(v) * `TICKS_PER_TENTH);
  endfunction

  function automatic logic [19:0] phase_ticks(input drive_seq_pkg::seq_state_t st,
                                              input logic [5:0][31:0] c);
    case (st)
      drive_seq_pkg::ST_START_BRAKE: return tenths(15'(c[2][`F_START_BRK_TIME]));
      drive_seq_pkg::ST_EXCITE:      return tenths(15'(c[2][`F_START_BRK_TIME]));
      drive_seq_pkg::ST_START_HOLD:  return 20'(c[1][`F_START_HOLD]);
      drive_seq_pkg::ST_STOP_WAIT:   return tenths(15'(c[4][`F_STOP_BRK_WAIT]));
      drive_seq_pkg::ST_STOP_BRAKE:  return tenths(15'(c[4][`F_STOP_BRK_TIME]));
      drive_seq_pkg::ST_STOP_HOLD:   return tenths(15'(c[4][`F_STOP_HOLD]));
      drive_seq_pkg::ST_DEAD_ZONE:   return tenths(c[5][`F_DEAD_TIME]);
      drive_seq_pkg::ST_RESTART:     return tenths(15'(c[5][`F_PWR_WAIT]));
      default:                       return 20'h0;
    endcase
  endfunction

  // ****************************
  // Frequency qualification
  // ****************************
  assign wr_idx        = reg_index(REG_ADDR);
  assign rd_idx        = reg_index(REG_ADDR);
  assign below_lower   = SET_FREQ < LOWER_LIMIT;
  assign stop_by_lower = below_lower && s.cfg[0][`F_BELOW_LOWER] == 2'h1;
  assign zero_by_lower = below_lower && s.cfg[0][`F_BELOW_LOWER] != 2'h0;
  assign lower_tgt     = !below_lower ? SET_FREQ :
                         (s.cfg[0][`F_BELOW_LOWER] == 2'h0 ? LOWER_LIMIT : 16'h0);
  assign below_start   = !zero_by_lower && lower_tgt < s.cfg[1][`F_START_FREQ];
  assign go            = !stop_by_lower && !(below_start && !s.cfg[0][`F_BELOW_START]);
  assign tgt           = below_start ? 16'h0 : lower_tgt;
  assign rev_refused   = s.rev_s2 && s.cfg[0][`F_REV_PROHIBIT];
  assign run_ok        = s.run_s2 && !s.boot && !s.block && !rev_refused;
  assign hold_bypass   = s.cfg[1][`F_START_HOLD] == 16'h0 || tgt == 16'h0;

  // ****************************
  // Next state
  // ****************************
  always_comb begin
    drive_seq_pkg::seq_state_t start_st;
    drive_seq_pkg::seq_state_t hold_st;
    hold_st  = hold_bypass ? drive_seq_pkg::ST_RUN : drive_seq_pkg::ST_START_HOLD;
    start_st = hold_st;
    n        = s;
    n.rdata  = 32'h0;
    n.tick   = 1'b0;
    n.run_s1 = RUN_CMD;
    n.run_s2 = s.run_s1;
    n.rev_s1 = REV_CMD;
    n.rev_s2 = s.rev_s1;
    n.pok_s1 = POWER_OK;
    n.pok_s2 = s.pok_s1;
    // Single timebase for every interval
    if (s.div == 22'(TICK_CYCLES - 1)) begin
      n.div  = 22'h0;
      n.tick = 1'b1;
    end else begin
      n.div = s.div + 22'h1;
    end
    if (s.tick && s.timer != 20'h0) begin
      n.timer = s.timer - 20'h1;
    end
    // Register port
    if (REG_WR && wr_idx < `REG_COUNT) begin
      n.cfg[wr_idx] = REG_WDATA;
    end
    if (REG_RD) begin
      if (rd_idx < `REG_COUNT) begin
        n.rdata = s.cfg[rd_idx];
      end else if (rd_idx == `REG_COUNT) begin
        n.rdata = {24'h0, s.state, s.dir, s.drv.out_en, s.boot, s.block};
      end
    end
    // Start path choice
    case (s.cfg[0][`F_START_MODE])
      2'h0: begin
        start_st = (s.cfg[2][`F_START_BRK_TIME] != 10'h0) ?
                   drive_seq_pkg::ST_START_BRAKE : hold_st;
      end
      2'h1: begin
        start_st = drive_seq_pkg::ST_TRACK;
      end
      2'h2: begin
        start_st = (s.cfg[2][`F_START_BRK_TIME] != 10'h0) ?
                   drive_seq_pkg::ST_EXCITE : hold_st;
      end
      default: begin
        start_st = hold_st;
      end
    endcase
    // Power-on behaviour
    if (s.block && !s.run_s2) begin
      n.block = 1'b0;
    end
    case (s.state)
      drive_seq_pkg::ST_IDLE: begin
        if (s.boot && s.pok_s2) begin
          n.boot = 1'b0;
          if (s.run_s2 && !s.cfg[0][`F_PWR_RESTART]) begin
            n.state = drive_seq_pkg::ST_RESTART;
          end else if (s.run_s2) begin
            n.block = 1'b1;
          end
        end else if (run_ok && go) begin
          n.dir   = s.rev_s2;
          n.state = start_st;
        end
      end
      drive_seq_pkg::ST_RESTART: begin
        if (!s.run_s2) begin
          n.state = drive_seq_pkg::ST_IDLE;
        end else if (s.timer == 20'h0 && run_ok && go) begin
          n.dir   = s.rev_s2;
          n.state = start_st;
        end
      end
      drive_seq_pkg::ST_START_BRAKE, drive_seq_pkg::ST_EXCITE: begin
        if (!run_ok) begin
          n.state = drive_seq_pkg::ST_IDLE;
        end else if (s.timer == 20'h0) begin
          n.state = hold_st;
        end
      end
      drive_seq_pkg::ST_TRACK: begin
        if (!run_ok) begin
          n.state = drive_seq_pkg::ST_IDLE;
        end else if (TRACK_DONE) begin
          n.state = drive_seq_pkg::ST_RUN;
        end
      end
      drive_seq_pkg::ST_START_HOLD: begin
        if (!run_ok) begin
          n.state = drive_seq_pkg::ST_IDLE;
        end else if (s.timer == 20'h0) begin
          n.state = drive_seq_pkg::ST_RUN;
        end
      end
      drive_seq_pkg::ST_RUN: begin
        if (!run_ok || !go) begin
          n.state = s.cfg[0][`F_STOP_MODE] ? drive_seq_pkg::ST_IDLE
                                           : drive_seq_pkg::ST_DEC;
        end else if (s.rev_s2 != s.dir) begin
          n.rev_pend = 1'b1;
          n.state    = drive_seq_pkg::ST_DEC;
        end
      end
      drive_seq_pkg::ST_DEC: begin
        if (s.rev_pend && run_ok && go) begin
          if (RAMP_FREQ == 16'h0) begin
            if (s.cfg[5][`F_DEAD_TIME] != 15'h0) begin
              n.state = drive_seq_pkg::ST_DEAD_ZONE;
            end else begin
              n.dir      = s.rev_s2;
              n.rev_pend = 1'b0;
              n.state    = drive_seq_pkg::ST_RUN;
            end
          end
        end else if (run_ok && go) begin
          n.state = drive_seq_pkg::ST_RUN;
        end else begin
          n.rev_pend = 1'b0;
          if (s.cfg[4][`F_STOP_BRK_TIME] != 10'h0 &&
              RAMP_FREQ <= s.cfg[3][`F_STOP_BRK_FREQ]) begin
            n.state = drive_seq_pkg::ST_STOP_WAIT;
          end else if (RAMP_FREQ <= s.cfg[3][`F_STOP_FREQ]) begin
            n.state = drive_seq_pkg::ST_STOP_HOLD;
          end else if (RAMP_FREQ == 16'h0) begin
            n.state = drive_seq_pkg::ST_IDLE;
          end
        end
      end
      drive_seq_pkg::ST_DEAD_ZONE: begin
        if (!run_ok || !go) begin
          n.rev_pend = 1'b0;
          n.state    = drive_seq_pkg::ST_IDLE;
        end else if (s.timer == 20'h0) begin
          n.dir      = s.rev_s2;
          n.rev_pend = 1'b0;
          n.state    = drive_seq_pkg::ST_RUN;
        end
      end
      drive_seq_pkg::ST_STOP_WAIT: begin
        if (s.timer == 20'h0) begin
          n.state = drive_seq_pkg::ST_STOP_BRAKE;
        end
      end
      drive_seq_pkg::ST_STOP_BRAKE, drive_seq_pkg::ST_STOP_HOLD: begin
        if (s.timer == 20'h0) begin
          n.state = drive_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        n.state = drive_seq_pkg::ST_IDLE;
      end
    endcase
    // Phase entry samples its duration and held frequency
    if (n.state != s.state) begin
      n.timer = phase_ticks(n.state, s.cfg);
      n.hold_freq = (n.state == drive_seq_pkg::ST_STOP_HOLD) ? s.cfg[3][`F_STOP_FREQ]
                                                           : s.cfg[1][`F_START_FREQ];
    end
    if (s.state == drive_seq_pkg::ST_RUN || s.state == drive_seq_pkg::ST_DEC) begin
      n.last_freq = RAMP_FREQ;
    end
    // Drive command
    n.drv               = '0;
    n.drv.track_rate    = s.cfg[0][`F_TRACK_RATE];
    n.drv.track_current = s.cfg[0][`F_TRACK_CURRENT];
    n.drv.rotate_rev    = n.dir ^ s.cfg[0][`F_DIR_INVERT];
    case (n.state)
      drive_seq_pkg::ST_START_BRAKE: begin
        n.drv.out_en      = 1'b1;
        n.drv.dc_brake    = 1'b1;
        n.drv.current_pct = {1'b0, s.cfg[2][`F_START_BRK_CUR]};
      end
      drive_seq_pkg::ST_EXCITE: begin
        n.drv.out_en      = 1'b1;
        n.drv.pre_excite  = 1'b1;
        n.drv.current_pct = {1'b0, s.cfg[2][`F_START_BRK_CUR]};
      end
      drive_seq_pkg::ST_TRACK: begin
        n.drv.out_en       = 1'b1;
        n.drv.track_active = 1'b1;
        n.drv.current_pct  = s.cfg[0][`F_TRACK_CURRENT];
        case (s.cfg[0][`F_TRACK_MODE])
          2'h0:    n.drv.track_init_freq = s.last_freq;
          2'h1:    n.drv.track_init_freq = 16'h0;
          default: n.drv.track_init_freq = MAX_FREQ;
        endcase
      end
      drive_seq_pkg::ST_START_HOLD: begin
        n.drv.out_en       = 1'b1;
        n.drv.freq_cmd     = n.hold_freq;
        n.drv.prog_time_en = 1'b1;
      end
      drive_seq_pkg::ST_RUN: begin
        n.drv.out_en       = 1'b1;
        n.drv.freq_cmd     = tgt;
        n.drv.ramp_en      = 1'b1;
        n.drv.prog_time_en = 1'b1;
      end
      drive_seq_pkg::ST_DEC: begin
        n.drv.out_en  = 1'b1;
        n.drv.ramp_en = 1'b1;
      end
      drive_seq_pkg::ST_DEAD_ZONE: begin
        n.drv.out_en = 1'b1;
      end
      drive_seq_pkg::ST_STOP_HOLD: begin
        n.drv.out_en   = 1'b1;
        n.drv.freq_cmd = n.hold_freq;
      end
      drive_seq_pkg::ST_STOP_BRAKE: begin
        n.drv.out_en        = 1'b1;
        n.drv.dc_brake      = 1'b1;
        n.drv.cur_motor_ref = 1'b1;
        n.drv.current_pct   = {1'b0, s.cfg[2][`F_STOP_BRK_CUR]};
      end
      default: begin
        n.drv.out_en = 1'b0;
      end
    endcase
  end

  // ****************************
  // State register
  // ****************************
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      s        <= '0;
      s.cfg[0] <= `RST_MODES;
      s.cfg[1] <= `RST_START;
      s.cfg[2] <= `RST_BRAKE;
      s.cfg[3] <= `RST_STOP_FREQS;
      s.cfg[4] <= `RST_STOP_TIMES;
      s.cfg[5] <= `RST_RESTART;
      s.boot   <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign REG_RDATA = s.rdata;
  assign DRIVE     = s.drv;

  // ****************************
  // Checks
  // ****************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  sequence stop_wait_end_s;
    s.state == drive_seq_pkg::ST_STOP_WAIT ##1 s.state != drive_seq_pkg::ST_STOP_WAIT;
  endsequence

  sequence dead_zone_end_s;
    s.state == drive_seq_pkg::ST_DEAD_ZONE ##1 s.state != drive_seq_pkg::ST_DEAD_ZONE;
  endsequence

  chk_coast_stop_cut: assert property (
    (s.state == drive_seq_pkg::ST_RUN && !run_ok && s.cfg[0][`F_STOP_MODE])
    |=> (s.state == drive_seq_pkg::ST_IDLE && !DRIVE.out_en))
    else $error("coast stop did not cut output");

  chk_start_brake_direct: assert property (
    s.state == drive_seq_pkg::ST_START_BRAKE
    |-> ($past(s.cfg[0][`F_START_MODE]) == 2'h0 || $past(s.state) == s.state) && DRIVE.dc_brake)
    else $error("start braking outside direct start");

  chk_start_hold_freq: assert property (
    s.state == drive_seq_pkg::ST_START_HOLD
    |-> DRIVE.freq_cmd == s.hold_freq && !DRIVE.ramp_en && DRIVE.prog_time_en)
    else $error("start hold frequency wrong");

  chk_dead_zone_zero: assert property (
    s.state == drive_seq_pkg::ST_DEAD_ZONE |-> DRIVE.out_en && DRIVE.freq_cmd == 16'h0)
    else $error("dead zone not at zero frequency");

  chk_dead_zone_exit: assert property (
    dead_zone_end_s |-> s.state inside {drive_seq_pkg::ST_RUN, drive_seq_pkg::ST_IDLE})
    else $error("dead zone left through start hold");

  chk_brake_wait_then: assert property (
    stop_wait_end_s |-> s.state == drive_seq_pkg::ST_STOP_BRAKE && DRIVE.dc_brake)
    else $error("stop braking did not follow wait");

  chk_stop_brake_ref: assert property (
    s.state == drive_seq_pkg::ST_STOP_BRAKE |-> DRIVE.cur_motor_ref && DRIVE.out_en)
    else $error("stop braking current reference wrong");

  chk_dir_invert_map: assert property (
    DRIVE.rotate_rev == (s.dir ^ $past(s.cfg[0][`F_DIR_INVERT])))
    else $error("rotation not inverted as set");

  chk_held_run_block: assert property (
    s.block |-> s.state == drive_seq_pkg::ST_IDLE && !DRIVE.out_en)
    else $error("drive started on held run command");

  chk_reverse_refused: assert property (
    (s.state == drive_seq_pkg::ST_IDLE && rev_refused && !s.boot)
    |=> s.state == drive_seq_pkg::ST_IDLE)
    else $error("reverse run not refused");

  chk_standby_below: assert property (
    (s.state == drive_seq_pkg::ST_IDLE && !go && !s.boot) |=> !DRIVE.out_en)
    else $error("drive left standby below start frequency");

endmodule

`default_nettype wire

// [tb/drive_start_stop_sequencer_tb.sv]
// Purpose: Self-checking bench of the start/stop sequencer
// Assumes: Tick shortened to 4 cycles
// Notes:   Default stop frequency 0.50 Hz, all waits bounded
`default_nettype none

module drive_start_stop_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      clk;
  logic                      rst;
  logic [7:0]                addr;
  logic [31:0]               wdata;
  logic                      wr;
  logic                      rd;
  logic [31:0]               rdata;
  logic                      run;
  logic                      rev;
  logic                      pok;
  logic [15:0]               set_freq;
  logic [15:0]               lower;
  logic [15:0]               ramp;
  logic                      tdone;
  drive_seq_pkg::drive_cmd_t drv;
  int                        miscompares;
  int                        total_checks;

  drive_start_stop_sequencer #(.TICK_CYCLES(4)) drive_start_stop_sequencer_i (
    .CORE_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .RUN_CMD(run), .REV_CMD(rev), .POWER_OK(pok),
    .SET_FREQ(set_freq), .LOWER_LIMIT(lower), .MAX_FREQ(16'h1388),
    .RAMP_FREQ(ramp), .TRACK_DONE(tdone), .DRIVE(drv));

  motor_model motor_model_i (.clk(clk), .rst(rst), .drive(drv), .ramp_freq(ramp),
    .track_done(tdone));

  // ****************************
  // Helpers
  // ****************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask

  task automatic wait_out(input logic v, input int bound);
    int n;
    n = 0;
    while (drv.out_en !== v && n < bound) begin
      @(posedge clk);
      #1 n++;
    end
    chk("out_en", {31'h0, v}, {31'h0, drv.out_en});
  endtask

  task automatic stays_off(input int cycles);
    repeat (cycles) begin
      @(posedge clk);
      #1 if (drv.out_en !== 1'b0) chk("out_en idle", 32'h0, {31'h0, drv.out_en});
    end
    total_checks++;
  endtask

  // ****************************
  // Scenarios
  // ****************************
  task automatic held_run_restart();
    reg_rd(8'h00, 32'h01f4a100);
    reg_rd(8'h04, 32'h00000032);
    reg_rd(8'h0c, 32'h00320000);
    reg_rd(8'h1c, 32'h00000000);
    stays_off(20);
    @(posedge clk);
    pok <= 1'b1;
    wait_out(1'b1, 100);
    @(posedge clk);
    run <= 1'b0;
    wait_out(1'b0, 200);
  endtask

  task automatic hold_then_ramp();
    int n;
    reg_wr(8'h04, 32'h00020032);
    run <= 1'b1;
    wait_out(1'b1, 20);
    chk("hold freq", 32'h0032, {16'h0, drv.freq_cmd});
    chk("hold prog", 32'h1, {31'h0, drv.prog_time_en});
    chk("hold ramp", 32'h0, {31'h0, drv.ramp_en});
    n = 0;
    while (drv.ramp_en !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk("hold span", 32'h1, {31'h0, n >= 6 && n <= 9});
    chk("run freq", {16'h0, set_freq}, {16'h0, drv.freq_cmd});
    @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("dec freq", 32'h0, {16'h0, drv.freq_cmd});
    chk("dec ramp", 32'h1, {31'h0, drv.ramp_en});
    wait_out(1'b0, 200);
  endtask

  task automatic coast_stop();
    reg_wr(8'h00, 32'h01f4a110);
    run <= 1'b1;
    wait_out(1'b1, 20);
    repeat (20) @(posedge clk);
    run <= 1'b0;
    wait_out(1'b0, 5);
  endtask

  task automatic invert_dir();
    reg_wr(8'h00, 32'h01f4a300);
    run <= 1'b1;
    wait_out(1'b1, 20);
    chk("rotate_rev", 32'h1, {31'h0, drv.rotate_rev});
    @(posedge clk);
    run <= 1'b0;
    wait_out(1'b0, 200);
  endtask

  task automatic refused(input logic [31:0] modes, input logic [15:0] f, input logic r);
    reg_wr(8'h00, modes);
    set_freq <= f;
    rev <= r;
    run <= 1'b1;
    stays_off(30);
    @(posedge clk);
    run <= 1'b0;
    rev <= 1'b0;
    set_freq <= 16'h03e8;
    repeat (4) @(posedge clk);
  endtask

  task automatic track_start();
    reg_wr(8'h00, 32'h01f4a109);
    run <= 1'b1;
    wait_out(1'b1, 20);
    chk("track on", 32'h1, {31'h0, drv.track_active});
    chk("track from", 32'h1388, {16'h0, drv.track_init_freq});
    chk("track rate", 32'h14, {25'h0, drv.track_rate});
    chk("track cur", 32'h7d, {24'h0, drv.track_current});
    @(posedge clk);
    run <= 1'b0;
    wait_out(1'b0, 200);
  endtask

  task automatic brake_start_stop();
    int n;
    reg_wr(8'h00, 32'h01f4a100);
    reg_wr(8'h08, 32'h00010f28);
    reg_wr(8'h0c, 32'h00320064);
    reg_wr(8'h10, 32'h00000400);
    run <= 1'b1;
    wait_out(1'b1, 20);
    chk("brake on", 32'h1, {31'h0, drv.dc_brake});
    chk("brake cur", 32'h28, {24'h0, drv.current_pct});
    n = 0;
    while (drv.dc_brake !== 1'b0 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    chk("brake span", 32'h1, {31'h0, n >= 38 && n <= 41});
    chk("brake then start", 32'h0032, {16'h0, drv.freq_cmd});
    repeat (20) @(posedge clk);
    run <= 1'b0;
    n = 0;
    while (drv.dc_brake !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    chk("stop brake ref", 32'h1, {31'h0, drv.cur_motor_ref});
    chk("stop brake cur", 32'h1e, {24'h0, drv.current_pct});
    wait_out(1'b0, 60);
  endtask

  task automatic held_run_block();
    @(posedge clk);
    rst <= 1'b1;
    pok <= 1'b0;
    run <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    reg_wr(8'h00, 32'h01f4a120);
    pok <= 1'b1;
    stays_off(30);
    reg_rd(8'h18, 32'h00000001);
    @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
    run <= 1'b1;
    wait_out(1'b1, 20);
    @(posedge clk);
    run <= 1'b0;
    wait_out(1'b0, 200);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst = 1'b1; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    run = 1'b1; rev = 1'b0; pok = 1'b0; set_freq = 16'h03e8;
    lower = 16'h0000;
    miscompares = 0; total_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    held_run_restart();
    hold_then_ramp();
    refused(32'h01f4a000, 16'h000a, 1'b0);
    refused(32'h01f4a500, 16'h03e8, 1'b1);
    lower <= 16'h0064;
    refused(32'h01f4a140, 16'h0050, 1'b0);
    lower <= 16'h0000;
    invert_dir();
    coast_stop();
    track_start();
    brake_start_stop();
    held_run_block();
    close_out();
  end

  initial begin
    #200000;
    miscompares++;
    close_out();
  end
endmodule

`default_nettype wire

// [tb/motor_model.sv]
// Purpose: Motor and ramp stand-in at the drive command side
// Assumes: Ramp moves 0.50 Hz per cycle while ramping is allowed
// Notes:   Output frequency drops to zero whenever output is off
`default_nettype none

module motor_model (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire drive_seq_pkg::drive_cmd_t drive,
  output var  logic [15:0]               ramp_freq,
  output var  logic                      track_done
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge clk) begin
    track_done <= drive.track_active & ~rst;
    if (rst || !drive.out_en) begin
      ramp_freq <= 16'h0000;
    end else if (!drive.ramp_en) begin
      ramp_freq <= drive.freq_cmd;
    end else if (ramp_freq + 16'h0032 < drive.freq_cmd) begin
      ramp_freq <= ramp_freq + 16'h0032;
    end else if (ramp_freq > drive.freq_cmd + 16'h0032) begin
      ramp_freq <= ramp_freq - 16'h0032;
    end else begin
      ramp_freq <= drive.freq_cmd;
    end
  end
endmodule

`default_nettype wire
